/* verilog/image_invert_accelerator.sv */
// image inversion accelerator behind a pci express endpoint core
// assumes the endpoint's user side: dma beats and single register
// accesses, all on ref_clk_in, synchronous active-low reset
//
// Summary of operation
// - frame buffer 320x240x3 bytes from address zero
// - image moves in and out only by dma
// - command/status register at window offset 0x10
// - a write to it while idle starts a run; writes during a run are ignored
// - reads nonzero while running, zero when done
// - result stays in the same frame buffer
// - fixed vendor and device identity codes
`timescale 1ns/1ps
`include "image_invert_defs.svh"

module image_invert_accelerator #(
	parameter logic [`IMG_WORD_IDX_W-1:0] IMAGE_WORDS = `IMG_WORDS
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// single register accesses
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [`REG_ADDR_W-1:0] reg_addr_in,
	input wire logic [`DATA_W-1:0] reg_wdata_in,
	output logic [`DATA_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// dma writes into the frame buffer
	input wire logic dma_wr_valid_in,
	output logic dma_wr_ready_out,
	input wire image_invert_pkg::dma_wr_beat_type dma_wr_beat_in,
	// dma read requests and returned words
	input wire logic dma_rd_valid_in,
	output logic dma_rd_ready_out,
	input wire logic [`IMG_BYTE_ADDR_W-1:0] dma_rd_addr_in,
	output logic dma_rd_dvalid_out,
	input wire logic dma_rd_dready_in,
	output logic [`DATA_W-1:0] dma_rd_data_out,
	// identity shown to the endpoint's configuration space
	output logic [15:0] vendor_code_out,
	output logic [15:0] device_code_out
);

	// ------------------------------------------------------------
	// frame buffer storage
	// ------------------------------------------------------------
	logic [`DATA_W-1:0] frame_mem [0:`IMG_WORDS-1];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	image_invert_pkg::run_state_type state_q, state_d;
	logic [`IMG_WORD_IDX_W-1:0] idx_q, idx_d;
	logic wr_ready_q;
	logic rd_ready_q;
	logic pend_q, pend_d;
	image_invert_pkg::rd_word_type pend_word_q;
	logic [`DATA_W-1:0] reg_rdata_q;
	logic reg_rvalid_q;
	logic [`DATA_W-1:0] rd_out_data_q;
	logic rd_out_valid_q;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire cmd_hit = (reg_addr_in == `REG_CMD_STATUS_OFS);
	wire cmd_write = reg_wr_in && cmd_hit;
	wire is_idle = (state_q == image_invert_pkg::ST_IDLE);
	wire is_run = (state_q == image_invert_pkg::ST_RUN);
	// a write during a run is ignored: restarting would invert
	// the already processed words a second time
	wire start = cmd_write && is_idle;
	wire last_word = (idx_q == IMAGE_WORDS - 16'd1);

	wire [`IMG_WORD_IDX_W-1:0] wr_idx =
		dma_wr_beat_in.addr[`IMG_BYTE_ADDR_W-1:2];
	wire [`IMG_WORD_IDX_W-1:0] rd_idx =
		dma_rd_addr_in[`IMG_BYTE_ADDR_W-1:2];
	wire wr_in_range = (wr_idx < IMAGE_WORDS);
	wire rd_in_range = (rd_idx < IMAGE_WORDS);

	// image traffic only through the dma ports, not the registers
	wire wr_accept = dma_wr_valid_in && wr_ready_q;
	wire rd_accept = dma_rd_valid_in && rd_ready_q;
	wire wr_store = wr_accept && wr_in_range;

	// ------------------------------------------------------------
	// byte-lane merge of dma writes
	// ------------------------------------------------------------
	wire [`DATA_W-1:0] wr_old = frame_mem[wr_idx];
	wire [`DATA_W-1:0] wr_merged;

	genvar lane;
	generate
		for (lane = 0; lane < `BE_W; lane = lane + 1) begin : g_lane
			assign wr_merged[8*lane +: 8] = dma_wr_beat_in.be[lane] ?
				dma_wr_beat_in.data[8*lane +: 8] : wr_old[8*lane +: 8];
		end
	endgenerate

	// ------------------------------------------------------------
	// inversion sequencer
	// ------------------------------------------------------------
	wire [`DATA_W-1:0] inv_word = ~frame_mem[idx_q];

	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		case (state_q)
		image_invert_pkg::ST_IDLE: begin
			if (start) begin
				state_d = image_invert_pkg::ST_RUN;
				idx_d = '0;
			end
		end
		image_invert_pkg::ST_RUN: begin
			// one word per clock; done only after IMAGE_WORDS words
			if (last_word) begin
				state_d = image_invert_pkg::ST_IDLE;
			end else begin
				idx_d = idx_q + 16'd1;
			end
		end
		default: begin
			state_d = image_invert_pkg::ST_IDLE;
		end
		endcase
	end

	// ------------------------------------------------------------
	// read path: one word in flight, then the two-entry buffer
	// ------------------------------------------------------------
	logic buf_in_ready;
	logic buf_out_valid;
	image_invert_pkg::rd_word_type buf_out_word;
	image_invert_pkg::rd_word_type fetch_word;

	wire push = pend_q && buf_in_ready;
	// the output stage is a plain register after the buffer;
	// it refills whenever it is empty or being taken
	wire out_take = dma_rd_dvalid_out && dma_rd_dready_in;
	wire out_load = !rd_out_valid_q || out_take;
	wire buf_pop = buf_out_valid && out_load;

	assign fetch_word.data = rd_in_range ?
		frame_mem[rd_idx] : `READ_UNMAPPED;
	assign fetch_word.in_range = rd_in_range;
	assign pend_d = rd_accept || (pend_q && !push);

	read_skid_buffer u_buf (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(pend_q),
		.in_ready_out(buf_in_ready),
		.in_word_in(pend_word_q),
		.out_valid_out(buf_out_valid),
		.out_ready_in(out_load),
		.out_word_out(buf_out_word)
	);

	// ------------------------------------------------------------
	// register read value
	// ------------------------------------------------------------
	wire [`DATA_W-1:0] process_status_word =
		is_run ? `STATUS_BUSY : `STATUS_IDLE;
	wire [`DATA_W-1:0] reg_rd_value =
		cmd_hit ? process_status_word : `READ_UNMAPPED;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state_q <= image_invert_pkg::ST_IDLE;
			idx_q <= '0;
			wr_ready_q <= 1'b0;
			rd_ready_q <= 1'b0;
			pend_q <= 1'b0;
			reg_rvalid_q <= 1'b0;
			reg_rdata_q <= '0;
			rd_out_valid_q <= 1'b0;
			rd_out_data_q <= '0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			// dma is held off during a run so the host cannot
			// see half-inverted data
			wr_ready_q <= (state_d == image_invert_pkg::ST_IDLE);
			rd_ready_q <= (state_d == image_invert_pkg::ST_IDLE)
				&& !pend_d;
			pend_q <= pend_d;
			reg_rvalid_q <= reg_rd_in;
			reg_rdata_q <= reg_rd_in ? reg_rd_value : '0;
			if (out_load) begin
				rd_out_valid_q <= buf_pop;
				rd_out_data_q <= buf_out_word.data;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rd_accept) begin
			pend_word_q <= fetch_word;
		end
	end

	// ------------------------------------------------------------
	// frame buffer writes: dma when idle, inversion when running
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (is_run) begin
			frame_mem[idx_q] <= inv_word;
		end else if (wr_store) begin
			frame_mem[wr_idx] <= wr_merged;
		end
	end

	// ------------------------------------------------------------
	// identity
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		vendor_code_out <= `VENDOR_CODE;
		device_code_out <= `DEVICE_CODE;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign dma_wr_ready_out = wr_ready_q;
	assign dma_rd_ready_out = rd_ready_q;
	assign dma_rd_dvalid_out = rd_out_valid_q;
	assign dma_rd_data_out = rd_out_data_q;
	assign reg_rdata_out = reg_rdata_q;
	assign reg_rvalid_out = reg_rvalid_q;

	wire unused_ok = &{1'b0, reg_wdata_in, buf_out_word.in_range};

endmodule

/* verilog/image_invert_defs.svh */
// constants of the image inversion block: offsets, widths, counts
// assumes byte addresses from the endpoint core's user side
`ifndef IMAGE_INVERT_DEFS_SVH
`define IMAGE_INVERT_DEFS_SVH

// ------------------------------------------------------------
// frame buffer
// ------------------------------------------------------------
`define IMG_WIDTH_PIX 320
`define IMG_HEIGHT_PIX 240
`define IMG_BYTES_PER_PIX 3
`define IMG_BASE_ADDR 18'h00000
`define IMG_BYTE_ADDR_W 18
`define IMG_WORD_IDX_W 16
`define IMG_WORDS 16'd57600
`define DATA_W 32
`define BE_W 4

// ------------------------------------------------------------
// user base address window
// ------------------------------------------------------------
`define REG_ADDR_W 8
`define REG_CMD_STATUS_OFS 8'h10
`define STATUS_BUSY 32'h00000001
`define STATUS_IDLE 32'h00000000
`define READ_UNMAPPED 32'h00000000

// ------------------------------------------------------------
// identity, values arbitrary
// ------------------------------------------------------------
`define VENDOR_CODE 16'h5a5a
`define DEVICE_CODE 16'h0c0d

`endif

/* verilog/image_invert_pkg.sv */
// types shared by the image inversion block and its read buffer
// assumes image_invert_defs.svh on the include path
`include "image_invert_defs.svh"

package image_invert_pkg;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} run_state_type;

	// ------------------------------------------------------------
	// dma beats
	// ------------------------------------------------------------
	typedef struct packed {
		logic [`IMG_BYTE_ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
		logic [`BE_W-1:0] be;
	} dma_wr_beat_type;

	typedef struct packed {
		logic [`DATA_W-1:0] data;
		logic in_range;
	} rd_word_type;

endpackage

/* verilog/read_skid_buffer.sv */
// two-entry buffer in the dma read data path
// assumes one clock shared with the endpoint core, synchronous reset
`timescale 1ns/1ps

module read_skid_buffer (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire image_invert_pkg::rd_word_type in_word_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output image_invert_pkg::rd_word_type out_word_out
);

	// ------------------------------------------------------------
	// storage: head drives the output, tail catches a stalled word
	// ------------------------------------------------------------
	image_invert_pkg::rd_word_type head_q, head_d;
	image_invert_pkg::rd_word_type tail_q, tail_d;
	logic [1:0] count_q, count_d;

	wire push = in_valid_in && (count_q != 2'd2);
	wire pop = out_valid_out && out_ready_in;

	assign in_ready_out = (count_q != 2'd2);
	assign out_valid_out = (count_q != 2'd0);
	assign out_word_out = head_q;

	always_comb begin
		head_d = head_q;
		tail_d = tail_q;
		count_d = count_q;
		case ({push, pop})
		2'b10: begin
			if (count_q == 2'd0) begin
				head_d = in_word_in;
			end else begin
				tail_d = in_word_in;
			end
			count_d = count_q + 2'd1;
		end
		2'b01: begin
			head_d = tail_q;
			count_d = count_q - 2'd1;
		end
		2'b11: begin
			if (count_q == 2'd1) begin
				head_d = in_word_in;
			end else begin
				head_d = tail_q;
				tail_d = in_word_in;
			end
		end
		default: begin
			count_d = count_q;
		end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			count_q <= 2'd0;
		end else begin
			count_q <= count_d;
		end
		head_q <= head_d;
		tail_q <= tail_d;
	end

endmodule

/* dv/image_invert_chk.sv */
// port assertions for the image inversion block
// assumes a bind into image_invert_accelerator, one clock
`timescale 1ns/1ps
`include "image_invert_defs.svh"
module image_invert_chk #(
	parameter logic [`IMG_WORD_IDX_W-1:0] IMAGE_WORDS = `IMG_WORDS
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [`REG_ADDR_W-1:0] reg_addr_in,
	input wire logic [`DATA_W-1:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic dma_wr_ready_out,
	input wire logic dma_rd_valid_in,
	input wire logic dma_rd_ready_out,
	input wire logic dma_rd_dvalid_out,
	input wire logic dma_rd_dready_in,
	input wire logic [`DATA_W-1:0] dma_rd_data_out,
	input wire logic [15:0] vendor_code_out,
	input wire logic [15:0] device_code_out
);
	// ------------------------------------------------------------
	// busy span counter: a hung sequencer shows as a long span
	// ------------------------------------------------------------
	logic [16:0] busy_q;
	logic [16:0] busy_d;
	logic start;
	logic at_reg;
	assign at_reg = reg_addr_in == `REG_CMD_STATUS_OFS;
	assign start = reg_wr_in && at_reg && dma_wr_ready_out;
	assign busy_d = dma_wr_ready_out ? 17'h00000 : busy_q + 17'h00001;
	always_ff @(posedge ref_clk_in) begin
		busy_q <= resetn_in ? busy_d : 17'h00000;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	run_bound_a: assert property (
		busy_q <= {1'b0, IMAGE_WORDS} + 17'h00003) else $error("run overran");
	start_busy_a: assert property (
		start |-> ##2 !dma_wr_ready_out) else $error("start ignored");
	busy_read_a: assert property (
		start ##1 (reg_rd_in && at_reg) |=> reg_rdata_out == `STATUS_BUSY)
		else $error("busy not shown");
	rd_answer_a: assert property (
		reg_rd_in |=> reg_rvalid_out) else $error("read unanswered");
	unmapped_rd_a: assert property (
		reg_rd_in && !at_reg |=> reg_rdata_out == `READ_UNMAPPED)
		else $error("unmapped read not zero");
	word_hold_a: assert property (
		dma_rd_dvalid_out && !dma_rd_dready_in |=>
		dma_rd_dvalid_out && $stable(dma_rd_data_out))
		else $error("returned word lost");
	req_gap_a: assert property (
		dma_rd_valid_in && dma_rd_ready_out |=> !dma_rd_ready_out)
		else $error("read ready not dropped");
	ident_a: assert property (
		vendor_code_out == `VENDOR_CODE && device_code_out == `DEVICE_CODE)
		else $error("identity changed");
endmodule
bind image_invert_accelerator image_invert_chk #(.IMAGE_WORDS(IMAGE_WORDS))
	chk (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
	.dma_wr_ready_out(dma_wr_ready_out), .dma_rd_valid_in(dma_rd_valid_in),
	.dma_rd_ready_out(dma_rd_ready_out), .dma_rd_dvalid_out(dma_rd_dvalid_out),
	.dma_rd_dready_in(dma_rd_dready_in), .dma_rd_data_out(dma_rd_data_out),
	.vendor_code_out(vendor_code_out), .device_code_out(device_code_out));

/* dv/endpoint_model.sv */
// host side model of the endpoint core: register and dma traffic
// assumes image_invert_accelerator on the far side, one clock
`timescale 1ns/1ps
`include "image_invert_defs.svh"
module endpoint_model (
	input wire logic ref_clk_in,
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [`REG_ADDR_W-1:0] reg_addr_out,
	output logic [`DATA_W-1:0] reg_wdata_out,
	input wire logic [`DATA_W-1:0] reg_rdata_in,
	input wire logic reg_rvalid_in,
	output logic dma_wr_valid_out,
	input wire logic dma_wr_ready_in,
	output image_invert_pkg::dma_wr_beat_type dma_wr_beat_out,
	output logic dma_rd_valid_out,
	input wire logic dma_rd_ready_in,
	output logic [`IMG_BYTE_ADDR_W-1:0] dma_rd_addr_out,
	input wire logic dma_rd_dvalid_in,
	output logic dma_rd_dready_out,
	input wire logic [`DATA_W-1:0] dma_rd_data_in
);
	// ------------------------------------------------------------
	// transfers: released lines carry inverted values, never stale
	// ------------------------------------------------------------
	logic stall = 1'b0;
	logic [`DATA_W-1:0] rx_q[$];
	assign dma_rd_dready_out = !stall;
	initial begin
		{reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = '0;
		{dma_wr_valid_out, dma_wr_beat_out} = '0;
		{dma_rd_valid_out, dma_rd_addr_out} = '0;
	end
	always @(posedge ref_clk_in) begin
		if (dma_rd_dvalid_in && dma_rd_dready_out) begin
			rx_q.push_back(dma_rd_data_in);
		end
	end
	task automatic reg_op(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		reg_wr_out = wr;
		reg_rd_out = !wr;
		reg_addr_out = a;
		reg_wdata_out = d;
		@(posedge ref_clk_in);
		q = '0;
		#1;
		{reg_wr_out, reg_rd_out} = 2'b00;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
		// read data stands for one cycle only: take it at the edge
		// where the answer strobe is seen, a write just lets one pass
		do @(posedge ref_clk_in); while (!wr && reg_rvalid_in !== 1'b1);
		if (!wr) begin
			q = reg_rdata_in;
		end
		#1;
	endtask
	task automatic dma_wr(input image_invert_pkg::dma_wr_beat_type b);
		dma_wr_valid_out = 1'b1;
		dma_wr_beat_out = b;
		do @(posedge ref_clk_in); while (dma_wr_ready_in !== 1'b1);
		#1;
		dma_wr_valid_out = 1'b0;
		dma_wr_beat_out = ~b;
		@(posedge ref_clk_in);
		#1;
	endtask
	task automatic dma_rd(input logic [`IMG_BYTE_ADDR_W-1:0] a);
		dma_rd_valid_out = 1'b1;
		dma_rd_addr_out = a;
		do @(posedge ref_clk_in); while (dma_rd_ready_in !== 1'b1);
		#1;
		dma_rd_valid_out = 1'b0;
		dma_rd_addr_out = ~a;
		@(posedge ref_clk_in);
		#1;
	endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the image inversion block
// assumes the design, its checker and the endpoint model compile first
`timescale 1ns/1ps
`include "image_invert_defs.svh"
module testbench;
	logic ref_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic reg_wr_in, reg_rd_in, dma_wr_valid_in, dma_wr_ready_out;
	logic dma_rd_valid_in, dma_rd_ready_out, dma_rd_dvalid_out;
	logic dma_rd_dready_in;
	logic reg_rvalid_out;
	logic [`REG_ADDR_W-1:0] reg_addr_in;
	logic [`DATA_W-1:0] reg_wdata_in, reg_rdata_out, dma_rd_data_out;
	logic [`IMG_BYTE_ADDR_W-1:0] dma_rd_addr_in;
	image_invert_pkg::dma_wr_beat_type dma_wr_beat_in;
	logic [31:0] exp_w[16];
	int n_mismatch = 0;
	int tests_run = 0;
	always #12.5 ref_clk_in = ~ref_clk_in;
	endpoint_model ep (.ref_clk_in(ref_clk_in), .reg_wr_out(reg_wr_in),
		.reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in),
		.reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out),
		.reg_rvalid_in(reg_rvalid_out),
		.dma_wr_valid_out(dma_wr_valid_in), .dma_wr_ready_in(dma_wr_ready_out),
		.dma_wr_beat_out(dma_wr_beat_in), .dma_rd_valid_out(dma_rd_valid_in),
		.dma_rd_ready_in(dma_rd_ready_out), .dma_rd_addr_out(dma_rd_addr_in),
		.dma_rd_dvalid_in(dma_rd_dvalid_out),
		.dma_rd_dready_out(dma_rd_dready_in), .dma_rd_data_in(dma_rd_data_out));
	// short run length keeps the bench quick; memory stays full size
	image_invert_accelerator #(.IMAGE_WORDS(16'h0010)) DUT (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out),
		.dma_wr_valid_in(dma_wr_valid_in),
		.dma_wr_ready_out(dma_wr_ready_out), .dma_wr_beat_in(dma_wr_beat_in),
		.dma_rd_valid_in(dma_rd_valid_in), .dma_rd_ready_out(dma_rd_ready_out),
		.dma_rd_addr_in(dma_rd_addr_in), .dma_rd_dvalid_out(dma_rd_dvalid_out),
		.dma_rd_dready_in(dma_rd_dready_in), .dma_rd_data_out(dma_rd_data_out),
		.vendor_code_out(), .device_code_out());
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic check(string what, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic t_load();
		logic [31:0] q;
		for (int i = 0; i < 16; i++) begin
			exp_w[i] = 32'h3c5a0f00 + 32'(i) * 32'h01010101;
			ep.dma_wr({18'(i * 4), exp_w[i], 4'hf});
		end
		ep.dma_wr({18'h0000c, 32'h123456aa, 4'h1});
		exp_w[3][7:0] = 8'haa;
		ep.dma_wr({18'h00040, 32'hdeadbeef, 4'hf});
		ep.reg_op(1'b0, `REG_CMD_STATUS_OFS, 32'h00000000, q);
		check("load idle", `STATUS_IDLE, q);
	endtask
	task automatic t_run();
		logic [31:0] q;
		int n;
		ep.reg_op(1'b1, `REG_CMD_STATUS_OFS, 32'h00000000, q);
		ep.reg_op(1'b0, `REG_CMD_STATUS_OFS, 32'h00000000, q);
		check("busy", `STATUS_BUSY, q);
		ep.reg_op(1'b1, `REG_CMD_STATUS_OFS, 32'hffffffff, q);
		n = 0;
		do begin
			ep.reg_op(1'b0, `REG_CMD_STATUS_OFS, 32'h00000000, q);
			n++;
		end while (q !== `STATUS_IDLE && n < 40);
		check("idle", `STATUS_IDLE, q);
		for (int i = 0; i < 16; i++) exp_w[i] = ~exp_w[i];
	endtask
	task automatic t_readback();
		int n;
		ep.rx_q.delete();
		ep.stall = 1'b1;
		fork
			begin
				repeat (24) @(posedge ref_clk_in);
				#1;
				ep.stall = 1'b0;
			end
		join_none
		for (int i = 0; i <= 16; i++) ep.dma_rd(18'(i * 4));
		n = 0;
		while (ep.rx_q.size() < 17 && n < 100) begin
			@(posedge ref_clk_in);
			n++;
		end
		check("count", 32'h00000011, 32'(ep.rx_q.size()));
		for (int i = 0; i < 16; i++) check("word", exp_w[i], ep.rx_q[i]);
		check("beyond", 32'h00000000, ep.rx_q[16]);
	endtask
	task automatic t_unmapped();
		logic [31:0] q;
		ep.reg_op(1'b0, 8'h04, 32'h00000000, q);
		check("unmapped", `READ_UNMAPPED, q);
		ep.reg_op(1'b1, 8'h14, 32'h00000001, q);
		ep.reg_op(1'b0, `REG_CMD_STATUS_OFS, 32'h00000000, q);
		check("no start", `STATUS_IDLE, q);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_in);
		#1;
		resetn_in = 1'b1;
		repeat (2) @(posedge ref_clk_in);
		#1;
		t_load();
		t_run();
		t_readback();
		t_run();
		t_readback();
		t_unmapped();
		print_verdict();
	end
	initial begin
		repeat (4000) @(posedge ref_clk_in);
		n_mismatch++;
		print_verdict();
	end
endmodule
